// >>> verilog/dcds_top.sv
// Purpose: per channel dimming counter, gated outputs and soft-start ramp
// Assumes: all pin inputs synchronous to CLK; channel clocks sampled as levels
// Notes: dimming clock divide factor is two to the power of the select field
//
// How it works
// - reference code eight or less forces off
// - select bit picks pin or counter dimming
// - each channel has ten bit counter
// - duty moves forward only on low write
// - pending duty loads at count 1022
// - dimming clock divided, period 1024 ticks
// - phase bit: 180 degrees or aligned
// - dimming low: gate, comp, fet off
// - dimming rise re-enables gate and fet
// - comp reconnects when sense exceeds comp
// - floating pin reads low, channel off
// - driver enable clear forces fet off
// - eight bit ramp, divided channel clock
// - ramp waits for selected dimming high
// - ramp holds while dimming low
// - two phase: one amplifier feeds both
// - two phase: channel one ramp, clocks antiphase
// - two phase internal: channel one duty
// - two phase: channel two faults ignored
// - three bit sense offset calibration field
// - gate-off bit turns channel off
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module dcds_top import dcds_pkg::*; #(
    parameter int DUTY_W = 10,
    parameter int RAMP_W = 8
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [1:0] EXTERNAL_DIMMING_INPUT,
    input wire logic [1:0] CHANNEL_SWITCHING_CLOCK,
    input wire logic [1:0] SENSE_ABOVE_COMP,
    input wire logic [3:0] CH2_FAULTS,
    output logic [1:0] MAIN_GATE_OUTPUT,
    output logic [1:0] SERIES_FET_DRIVER_OUTPUT,
    output logic [1:0] COMPENSATION_CONNECT,
    output logic CH2_ERROR_AMP_ENABLE,
    output logic COMP_SHARE,
    output logic CH2_CLOCK_OUT,
    output logic CH2_FAULT_OFF,
    output logic [7:0] REF_CODE1,
    output logic [7:0] REF_CODE2,
    output logic [7:0] SOFT_START_RAMP1,
    output logic [7:0] SOFT_START_RAMP2,
    output logic [2:0] SENSE_OFFSET1,
    output logic [2:0] SENSE_OFFSET2
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (DUTY_W != 10 || RAMP_W != 8) begin : g_width_chk
        $error("duty width must be 10 and ramp width 8");
    end
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [11:0] ctrl_reg;
    logic [7:0] ref1_reg, ref2_reg, ssdiv1_reg, ssdiv2_reg;
    logic [1:0] hi_reg [2];
    logic [7:0] lo_reg [2];
    logic [2:0] cal1_reg, cal2_reg, div_sel;
    logic bvalid_reg, rvalid_reg, wr_go, rd_go, dim_tick, int_sel, phase_sel, two_ph;
    logic [1:0] bresp_reg, rresp_reg, pend_reg, lo_wr, clk_prev_reg, comp_reg, drv_en, goff;
    logic [31:0] rdata_reg, rdata_next;
    logic [DUTY_W-1:0] cnt_reg [2], duty_reg [2];
    logic [RAMP_W-1:0] ramp_reg [2];
    logic [7:0] ssdiv_cnt_reg [2];
    logic [6:0] pre_reg;
    logic [1:0] dim_int, dim_sel, ref_ok, chan_on, ss_tick;
    assign int_sel = ctrl_reg[DCDS_INT_SEL_BIT];
    assign phase_sel = ctrl_reg[DCDS_PHASE_BIT];
    assign two_ph = ctrl_reg[DCDS_TWO_PH_BIT];
    assign div_sel = ctrl_reg[DCDS_DIV_LSB +: 3];
    assign drv_en = ctrl_reg[DCDS_DRV_EN_LSB +: 2];
    assign goff = ctrl_reg[DCDS_GOFF_LSB +: 2];

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    // address and data are taken together; the slave never holds one alone
    assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_reg;
    assign S_AXI_AWREADY = wr_go;
    assign S_AXI_WREADY = wr_go;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign lo_wr[0] = wr_go && S_AXI_AWADDR == DCDS_DUTY1_LO_OFS && S_AXI_WSTRB[0];
    assign lo_wr[1] = wr_go && S_AXI_AWADDR == DCDS_DUTY2_LO_OFS && S_AXI_WSTRB[0];

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= DCDS_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (S_AXI_AWADDR > DCDS_CAL_OFS || S_AXI_AWADDR[1:0] != 2'b00) ?
                DCDS_RESP_SLVERR : DCDS_RESP_OKAY;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= DCDS_CTRL_RST;
            ref1_reg <= DCDS_REF_RST;
            ref2_reg <= DCDS_REF_RST;
            hi_reg[0] <= 2'h0;
            hi_reg[1] <= 2'h0;
            lo_reg[0] <= 8'h00;
            lo_reg[1] <= 8'h00;
            ssdiv1_reg <= DCDS_SSDIV_RST;
            ssdiv2_reg <= DCDS_SSDIV_RST;
            cal1_reg <= 3'h0;
            cal2_reg <= 3'h0;
        end else if (wr_go) begin
            case (S_AXI_AWADDR)
                DCDS_CTRL_OFS: begin
                    if (S_AXI_WSTRB[0]) ctrl_reg[7:0] <= S_AXI_WDATA[7:0];
                    if (S_AXI_WSTRB[1]) ctrl_reg[11:8] <= S_AXI_WDATA[11:8];
                end
                DCDS_REF_OFS: begin
                    if (S_AXI_WSTRB[0]) ref1_reg <= S_AXI_WDATA[7:0];
                    if (S_AXI_WSTRB[1]) ref2_reg <= S_AXI_WDATA[15:8];
                end
                DCDS_DUTY1_HI_OFS: if (S_AXI_WSTRB[0]) hi_reg[0] <= S_AXI_WDATA[1:0];
                DCDS_DUTY1_LO_OFS: if (S_AXI_WSTRB[0]) lo_reg[0] <= S_AXI_WDATA[7:0];
                DCDS_DUTY2_HI_OFS: if (S_AXI_WSTRB[0]) hi_reg[1] <= S_AXI_WDATA[1:0];
                DCDS_DUTY2_LO_OFS: if (S_AXI_WSTRB[0]) lo_reg[1] <= S_AXI_WDATA[7:0];
                DCDS_SSDIV_OFS: begin
                    if (S_AXI_WSTRB[0]) ssdiv1_reg <= S_AXI_WDATA[7:0];
                    if (S_AXI_WSTRB[1]) ssdiv2_reg <= S_AXI_WDATA[15:8];
                end
                DCDS_CAL_OFS: if (S_AXI_WSTRB[0]) begin
                    cal1_reg <= S_AXI_WDATA[2:0];
                    cal2_reg <= S_AXI_WDATA[DCDS_CAL2_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    assign rd_go = S_AXI_ARVALID && !rvalid_reg;
    assign S_AXI_ARREADY = rd_go;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (S_AXI_ARADDR)
            DCDS_CTRL_OFS: rdata_next = {20'h00000, ctrl_reg};
            DCDS_REF_OFS: rdata_next = {16'h0000, ref2_reg, ref1_reg};
            DCDS_DUTY1_HI_OFS: rdata_next = {30'h0, hi_reg[0]};
            DCDS_DUTY1_LO_OFS: rdata_next = {24'h0, lo_reg[0]};
            DCDS_DUTY2_HI_OFS: rdata_next = {30'h0, hi_reg[1]};
            DCDS_DUTY2_LO_OFS: rdata_next = {24'h0, lo_reg[1]};
            DCDS_SSDIV_OFS: rdata_next = {16'h0000, ssdiv2_reg, ssdiv1_reg};
            DCDS_CAL_OFS: rdata_next = {25'h0, cal2_reg, 1'b0, cal1_reg};
            DCDS_STATUS_OFS: rdata_next = {8'h00, pend_reg, comp_reg, chan_on, dim_sel,
                ramp_reg[1], ramp_reg[0]};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= DCDS_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rdata_next;
            rresp_reg <= (S_AXI_ARADDR > DCDS_STATUS_OFS || S_AXI_ARADDR[1:0] != 2'b00) ?
                DCDS_RESP_SLVERR : DCDS_RESP_OKAY;
        end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // dimming prescaler and counters
    // ------------------------------------------------------------
    // one shared prescaler keeps both counters on the same tick, so phase stays exact
    assign dim_tick = (pre_reg & ((7'h01 << div_sel) - 7'h01)) == 7'h00;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre_reg <= 7'h00;
        end else begin
            pre_reg <= pre_reg + 7'h01;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_reg[0] <= DCDS_DUTY_RST;
            cnt_reg[1] <= DCDS_DUTY_RST;
        end else if (dim_tick) begin
            cnt_reg[0] <= cnt_reg[0] + 10'h001;
            // channel two realigns once a period so a phase change takes one period
            if (cnt_reg[0] == DCDS_LAST_CNT) begin
                cnt_reg[1] <= phase_sel ? DCDS_DUTY_RST : DCDS_HALF_CNT + 10'h001;
            end else begin
                cnt_reg[1] <= cnt_reg[1] + 10'h001;
            end
        end
    end

    // pending flag: a new low write in the load cycle wins over the clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pend_reg <= 2'b00;
            duty_reg[0] <= DCDS_DUTY_RST;
            duty_reg[1] <= DCDS_DUTY_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (lo_wr[i]) begin
                    pend_reg[i] <= 1'b1;
                end else if (dim_tick && cnt_reg[i] == DCDS_LOAD_CNT) begin
                    pend_reg[i] <= 1'b0;
                end
                if (dim_tick && cnt_reg[i] == DCDS_LOAD_CNT && pend_reg[i]) begin
                    duty_reg[i] <= {hi_reg[i], lo_reg[i]};
                end
            end
        end
    end

    assign dim_int[0] = cnt_reg[0] < duty_reg[0];
    assign dim_int[1] = two_ph ? dim_int[0] : cnt_reg[1] < duty_reg[1];

    // ------------------------------------------------------------
    // channel gating
    // ------------------------------------------------------------
    // a floating pin pulls low and the reset select is pin dimming, so all stays off
    assign dim_sel = int_sel ? dim_int : EXTERNAL_DIMMING_INPUT;
    assign ref_ok[0] = ref1_reg > DCDS_REF_OFF_MAX;
    assign ref_ok[1] = ref2_reg > DCDS_REF_OFF_MAX;
    assign chan_on = dim_sel & ref_ok & ~goff;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            MAIN_GATE_OUTPUT <= 2'b00;
            SERIES_FET_DRIVER_OUTPUT <= 2'b00;
        end else begin
            MAIN_GATE_OUTPUT <= chan_on;
            SERIES_FET_DRIVER_OUTPUT <= chan_on & drv_en;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            comp_reg <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!chan_on[i]) begin
                    comp_reg[i] <= 1'b0;
                end else if (SENSE_ABOVE_COMP[i]) begin
                    comp_reg[i] <= 1'b1;
                end
            end
        end
    end
    assign COMPENSATION_CONNECT = comp_reg;

    // ------------------------------------------------------------
    // soft-start ramp
    // ------------------------------------------------------------
    // ramp restarts from zero only when the channel is shut off by code or gate-off
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            clk_prev_reg <= 2'b00;
            ssdiv_cnt_reg[0] <= 8'h00;
            ssdiv_cnt_reg[1] <= 8'h00;
        end else begin
            clk_prev_reg <= CHANNEL_SWITCHING_CLOCK;
            for (int i = 0; i < 2; i++) begin
                if (CHANNEL_SWITCHING_CLOCK[i] && !clk_prev_reg[i]) begin
                    ssdiv_cnt_reg[i] <= ss_tick[i] ? 8'h00 : ssdiv_cnt_reg[i] + 8'h01;
                end
            end
        end
    end

    assign ss_tick[0] = CHANNEL_SWITCHING_CLOCK[0] && !clk_prev_reg[0] &&
        ssdiv_cnt_reg[0] == ssdiv1_reg;
    assign ss_tick[1] = CHANNEL_SWITCHING_CLOCK[1] && !clk_prev_reg[1] &&
        ssdiv_cnt_reg[1] == ssdiv2_reg;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ramp_reg[0] <= 8'h00;
            ramp_reg[1] <= 8'h00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!ref_ok[i] || goff[i]) begin
                    ramp_reg[i] <= 8'h00;
                end else if (ss_tick[i] && dim_sel[i] && ramp_reg[i] != DCDS_RAMP_TOP) begin
                    ramp_reg[i] <= ramp_reg[i] + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // two-phase routing and analog settings
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SOFT_START_RAMP1 <= 8'h00;
            SOFT_START_RAMP2 <= 8'h00;
            CH2_CLOCK_OUT <= 1'b0;
            CH2_ERROR_AMP_ENABLE <= 1'b1;
            COMP_SHARE <= 1'b0;
            CH2_FAULT_OFF <= 1'b0;
            REF_CODE1 <= 8'h00;
            REF_CODE2 <= 8'h00;
            SENSE_OFFSET1 <= 3'h0;
            SENSE_OFFSET2 <= 3'h0;
        end else begin
            SOFT_START_RAMP1 <= ramp_reg[0];
            SOFT_START_RAMP2 <= two_ph ? ramp_reg[0] : ramp_reg[1];
            CH2_CLOCK_OUT <= two_ph ? !CHANNEL_SWITCHING_CLOCK[0] :
                CHANNEL_SWITCHING_CLOCK[1];
            CH2_ERROR_AMP_ENABLE <= !two_ph;
            COMP_SHARE <= two_ph;
            CH2_FAULT_OFF <= !two_ph && (|CH2_FAULTS);
            REF_CODE1 <= ref1_reg;
            REF_CODE2 <= ref2_reg;
            SENSE_OFFSET1 <= cal1_reg;
            SENSE_OFFSET2 <= cal2_reg;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    ref_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (ref1_reg <= DCDS_REF_OFF_MAX) |=> !MAIN_GATE_OUTPUT[0])
        else $error("channel one on with low reference code");
    ext_ignored_a: assert property (@(posedge CLK) disable iff (!RST_N)
        int_sel |-> dim_sel[0] == dim_int[0]) else $error("pin dimming used in internal mode");
    duty_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !pend_reg[0] && !lo_wr[0] |=> $stable(duty_reg[0]))
        else $error("duty changed without low write");
    load_point_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $changed(duty_reg[0]) |-> $past(cnt_reg[0]) == DCDS_LOAD_CNT)
        else $error("duty loaded outside count 1022");
    phase_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
        dim_tick && cnt_reg[0] == DCDS_LAST_CNT && !phase_sel |=>
        cnt_reg[1] == cnt_reg[0] + DCDS_HALF_CNT + 10'h001)
        else $error("channel two not half a period behind");
    dim_low_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !dim_sel[1] |=> !MAIN_GATE_OUTPUT[1] && !SERIES_FET_DRIVER_OUTPUT[1]
        && !COMPENSATION_CONNECT[1])
        else $error("channel two active while dimming low");
    comp_wait_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(COMPENSATION_CONNECT[0]) |-> $past(SENSE_ABOVE_COMP[0]))
        else $error("comp reconnected before sense crossed");
    fet_enable_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !drv_en[0] |=> !SERIES_FET_DRIVER_OUTPUT[0])
        else $error("series fet on with driver disabled");
    ramp_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !dim_sel[0] && ref_ok[0] && !goff[0] |=> $stable(ramp_reg[0]))
        else $error("ramp moved while dimming low");
    two_phase_a: assert property (@(posedge CLK) disable iff (!RST_N)
        two_ph && int_sel |-> dim_sel[1] == dim_sel[0])
        else $error("channel two not following channel one duty");
    gate_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
        goff[0] |=> !MAIN_GATE_OUTPUT[0] ##1 !MAIN_GATE_OUTPUT[0] || !goff[0])
        else $error("gate-off did not hold channel off");
endmodule // dcds_top

// >>> verilog/dcds_pkg.sv
// Purpose: shared constants for the dual channel dimming and soft-start block
// Assumes: 32-bit AXI4-Lite register access, byte addresses below
// Notes: register layout is local to this block
package dcds_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] DCDS_CTRL_OFS = 8'h00;
    localparam logic [7:0] DCDS_REF_OFS = 8'h04;
    localparam logic [7:0] DCDS_DUTY1_HI_OFS = 8'h08;
    localparam logic [7:0] DCDS_DUTY1_LO_OFS = 8'h0c;
    localparam logic [7:0] DCDS_DUTY2_HI_OFS = 8'h10;
    localparam logic [7:0] DCDS_DUTY2_LO_OFS = 8'h14;
    localparam logic [7:0] DCDS_SSDIV_OFS = 8'h18;
    localparam logic [7:0] DCDS_CAL_OFS = 8'h1c;
    localparam logic [7:0] DCDS_STATUS_OFS = 8'h20;
    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int DCDS_INT_SEL_BIT = 0;
    localparam int DCDS_PHASE_BIT = 1;
    localparam int DCDS_TWO_PH_BIT = 2;
    localparam int DCDS_DIV_LSB = 4;
    localparam int DCDS_DRV_EN_LSB = 8;
    localparam int DCDS_GOFF_LSB = 10;
    localparam int DCDS_CH2_LSB = 8;
    localparam int DCDS_CAL2_LSB = 4;
    // ------------------------------------------------------------
    // reset values and thresholds
    // ------------------------------------------------------------
    localparam logic [11:0] DCDS_CTRL_RST = 12'h300;
    localparam logic [7:0] DCDS_REF_RST = 8'h00;
    localparam logic [7:0] DCDS_SSDIV_RST = 8'h00;
    localparam logic [7:0] DCDS_REF_OFF_MAX = 8'h08;
    localparam logic [9:0] DCDS_DUTY_RST = 10'h000;
    localparam logic [9:0] DCDS_LOAD_CNT = 10'h3fe;
    localparam logic [9:0] DCDS_HALF_CNT = 10'h1ff;
    localparam logic [9:0] DCDS_LAST_CNT = 10'h3ff;
    localparam logic [7:0] DCDS_RAMP_TOP = 8'hff;
    localparam logic [1:0] DCDS_RESP_OKAY = 2'b00;
    localparam logic [1:0] DCDS_RESP_SLVERR = 2'b10;
endpackage

// >>> bench/dcds_stage_model.sv
// Purpose: power stage stand-in giving switching clocks and sense comparator
// Assumes: gate high means the stage is switching
// Notes: sense trips a few cycles after gate rise, drops one cycle after gate falls
`timescale 1ns/1ps
module dcds_stage_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] gate,
    output logic [1:0] sw_clk,
    output logic [1:0] sense
);
    logic [2:0] div_reg;
    logic [1:0] d1_reg;
    logic [1:0] d2_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            div_reg <= 3'h0;
        else
            div_reg <= div_reg + 3'h1;
    end
    // channel two runs antiphase so shared-clock mixups show
    assign sw_clk = {~div_reg[2], div_reg[2]};
    // inductor current needs time to pass the comp level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            d1_reg <= 2'h0;
            d2_reg <= 2'h0;
            sense <= 2'h0;
        end else begin
            d1_reg <= gate;
            d2_reg <= d1_reg & gate;
            sense <= d2_reg & gate;
        end
    end
endmodule // dcds_stage_model

// >>> bench/dcds_top_tb_top.sv
// Purpose: self-checking bench for the dimming and soft-start block
// Assumes: AXI4-Lite master drives just after rising edges
// Notes: divide select kept low so periods stay short
`timescale 1ns/1ps
module dcds_top_tb_top import dcds_pkg::*; ;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} dcds_row_t;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [7:0] awa = 0, ara = 0, v;
    logic [31:0] wd = 0, rdata;
    logic [1:0] ext = 0, bresp, rresp, gate, fet, comp, swc, sns;
    logic [3:0] flt = 0;
    logic awr, wrdy, bv, arr, rv, c2a, csh, c2c, c2f;
    logic [7:0] rf1, rf2, rp1, rp2;
    logic [2:0] so1, so2;
    int num_errors = 0, total_checks = 0, g1, g2, bo, f1, c1, k1;
    dcds_row_t rows [5] = '{'{8'h00, 32'h301, 32'h301}, '{8'h04, 32'h6464, 32'h6464},
        '{8'h18, 32'h0, 32'h0}, '{8'h1c, 32'h75, 32'h75}, '{8'h00, 32'h300, 32'h300}};
    always #10 clk = ~clk;
    dcds_top u_dut (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
        .EXTERNAL_DIMMING_INPUT(ext), .CHANNEL_SWITCHING_CLOCK(swc), .SENSE_ABOVE_COMP(sns),
        .CH2_FAULTS(flt), .MAIN_GATE_OUTPUT(gate), .SERIES_FET_DRIVER_OUTPUT(fet),
        .COMPENSATION_CONNECT(comp), .CH2_ERROR_AMP_ENABLE(c2a), .COMP_SHARE(csh),
        .CH2_CLOCK_OUT(c2c), .CH2_FAULT_OFF(c2f), .REF_CODE1(rf1), .REF_CODE2(rf2),
        .SOFT_START_RAMP1(rp1), .SOFT_START_RAMP2(rp2), .SENSE_OFFSET1(so1),
        .SENSE_OFFSET2(so2));
    dcds_stage_model u_stage (.clk(clk), .rst_n(rst_n), .gate(gate), .sw_clk(swc),
        .sense(sns));
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic rdy(input int k);
        case (k)
            0: return awr;
            1: return bv;
            2: return arr;
            default: return rv;
        endcase
    endfunction
    // ready is looked at mid-cycle, the transfer happens at the next rise
    task automatic wt(input int k);
        int n;
        n = 0;
        @(negedge clk);
        while (rdy(k) !== 1'b1) begin
            n++;
            if (n > 50) begin
                num_errors++;
                end_of_test();
            end
            @(negedge clk);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        wt(0);
        @(posedge clk);
        awv <= 1'b0;
        wv <= 1'b0;
        wt(1);
        check(bresp, er, "bresp");
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        wt(2);
        @(posedge clk);
        arv <= 1'b0;
        wt(3);
        check(rdata, e, "rdata");
        check(rresp, er, "rresp");
        @(posedge clk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic cnt(input int n);
        g1 = 0;
        g2 = 0;
        bo = 0;
        f1 = 0;
        c1 = 0;
        k1 = 0;
        repeat (n) begin
            @(negedge clk);
            g1 += gate[0];
            g2 += gate[1];
            bo += gate[0] & gate[1];
            f1 += fet[0];
            c1 += comp[0];
            k1 += (c2c == swc[0]);
        end
        @(posedge clk);
    endtask
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        cyc(1);
        check(c2a, 1'b1, "amp_en");
        check(gate, 2'h0, "gate");
        rd(DCDS_CTRL_OFS, {20'h0, DCDS_CTRL_RST}, DCDS_RESP_OKAY);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, DCDS_RESP_OKAY);
            rd(rows[i].a, rows[i].e, DCDS_RESP_OKAY);
        end
        check({rf2, rf1}, 16'h6464, "ref");
        check({so2, so1}, 6'h3d, "offset");
        wr(8'h28, 32'h1, DCDS_RESP_SLVERR);
        rd(8'h24, 32'h0, DCDS_RESP_SLVERR);
        $display("registers done");
        cnt(300);
        check(g1, 0, "gate_pin_low");
        check(rp1, 8'h00, "ramp_wait");
        ext <= 2'h3;
        cnt(400);
        check(g1 > 390, 1, "gate_pin_high");
        ext <= 2'h0;
        cyc(4);
        v = rp1;
        cyc(300);
        check(rp1, v, "ramp_hold");
        ext <= 2'h3;
        cyc(2200);
        check(rp1, DCDS_RAMP_TOP, "ramp_top");
        wr(DCDS_REF_OFS, 32'h6408, DCDS_RESP_OKAY);
        cnt(200);
        check(g1, 0, "ref_off");
        check(rp1, 8'h00, "ramp_clr");
        wr(DCDS_REF_OFS, 32'h6409, DCDS_RESP_OKAY);
        cnt(200);
        check(g1 > 150, 1, "ref_on");
        $display("pin dimming done");
        ext <= 2'h0;
        wr(DCDS_DUTY1_HI_OFS, 32'h2, DCDS_RESP_OKAY);
        wr(DCDS_DUTY1_LO_OFS, 32'h0, DCDS_RESP_OKAY);
        wr(DCDS_DUTY2_HI_OFS, 32'h2, DCDS_RESP_OKAY);
        wr(DCDS_DUTY2_LO_OFS, 32'h0, DCDS_RESP_OKAY);
        wr(DCDS_CTRL_OFS, 32'h301, DCDS_RESP_OKAY);
        cyc(2100);
        cnt(1024);
        check(g1, 512, "duty");
        check(bo <= 2, 1, "antiphase");
        check(f1, g1, "fet");
        check(c1 > 0 && c1 < g1, 1, "comp");
        wr(DCDS_DUTY1_HI_OFS, 32'h1, DCDS_RESP_OKAY);
        cyc(2100);
        cnt(1024);
        check(g1, 512, "hi_only");
        wr(DCDS_DUTY1_LO_OFS, 32'h80, DCDS_RESP_OKAY);
        cyc(2100);
        cnt(1024);
        check(g1, 384, "lo_write");
        wr(DCDS_CTRL_OFS, 32'h303, DCDS_RESP_OKAY);
        cyc(2100);
        cnt(1024);
        check(bo, 384, "aligned");
        wr(DCDS_CTRL_OFS, 32'h313, DCDS_RESP_OKAY);
        cyc(4200);
        cnt(2048);
        check(g1, 768, "div_two");
        wr(DCDS_CTRL_OFS, 32'h703, DCDS_RESP_OKAY);
        cyc(2100);
        cnt(1024);
        check(g1, 0, "gate_off");
        check(g2, 512, "gate_off_ch2");
        wr(DCDS_CTRL_OFS, 32'h003, DCDS_RESP_OKAY);
        cyc(2100);
        cnt(1024);
        check(f1, 0, "fet_dis");
        check(g1, 384, "gate_on");
        $display("internal dimming done");
        wr(DCDS_SSDIV_OFS, 32'hff00, DCDS_RESP_OKAY);
        wr(DCDS_REF_OFS, 32'h0809, DCDS_RESP_OKAY);
        wr(DCDS_REF_OFS, 32'h6409, DCDS_RESP_OKAY);
        flt <= 4'h1;
        wr(DCDS_CTRL_OFS, 32'h307, DCDS_RESP_OKAY);
        cyc(2100);
        cnt(1024);
        check(c2a, 1'b0, "amp2");
        check(csh, 1'b1, "share");
        check(c2f, 1'b0, "fault2");
        check(g2, 384, "ch2_duty");
        check(rp2, rp1, "ramp2");
        check(k1, 256, "ch2_clock");
        wr(DCDS_CTRL_OFS, 32'h303, DCDS_RESP_OKAY);
        cyc(4);
        check(c2f, 1'b1, "fault2_on");
        $display("two phase done");
        rst_n <= 1'b0;
        cyc(3);
        check(gate, 2'h0, "rst_gate");
        check(c2a, 1'b1, "rst_amp");
        check(rp1, 8'h00, "rst_ramp");
        rst_n <= 1'b1;
        cyc(1);
        rd(DCDS_CTRL_OFS, {20'h0, DCDS_CTRL_RST}, DCDS_RESP_OKAY);
        $display("reset done");
        end_of_test();
    end
endmodule // dcds_top_tb_top
